// ===== ext_irq_pkg.sv
//
// Purpose: constants, encodings and carriers for the external interrupt front end
// Assumes: gear clock is mclk at 20 MHz
// Notes:   one control register for the fourth source, byte wide
//
package ext_irq_pkg;

    // ************************************************************
    // register bus
    // ************************************************************
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 8;
    localparam logic [11:0] CTL4_ADDR    = 12'hfdb;
    localparam logic [7:0]  CTL4_RESET   = 8'h00;
    localparam logic [7:0]  RDATA_IDLE   = 8'h00;
    localparam int          LVL_BIT      = 4;
    localparam int          TRIG_LSB     = 2;
    localparam int          INTV_LSB     = 0;
    localparam int          RSVD_MSB     = 7;
    localparam int          RSVD_LSB     = 5;
    localparam logic [2:0]  RSVD_VALUE   = 3'h0;

    // ************************************************************
    // sources and timing
    // ************************************************************
    localparam int          NUM_SRC      = 6;
    localparam int          LVL_SRC      = 4;
    localparam logic [5:0]  FIXED_MASK   = 6'h21;
    localparam int          PRESC_W      = 4;
    localparam logic [3:0]  PRESC_ZERO   = 4'h0;
    localparam logic [3:0]  PRESC_STEP   = 4'h1;
    localparam logic [1:0]  LF_DIV_LAST  = 2'h3;
    localparam logic [1:0]  LF_STEP      = 2'h1;
    localparam int          MCLK_HZ      = 20_000_000;
    localparam int          MCLK_PERIOD_NS = 1_000_000_000 / MCLK_HZ;

    typedef enum logic [1:0] {
        TRIG_RISE = 2'h0,
        TRIG_FALL = 2'h1,
        TRIG_BOTH = 2'h2,
        TRIG_HIGH = 2'h3
    } trig_type;

    typedef enum logic [1:0] {
        INTV_DIV1  = 2'h0,
        INTV_DIV4  = 2'h1,
        INTV_DIV8  = 2'h2,
        INTV_DIV16 = 2'h3
    } intv_type;

    typedef enum logic [2:0] {
        MODE_FAST = 3'h1,
        MODE_SLOW = 3'h2,
        MODE_HALT = 3'h4
    } power_mode_type;

    typedef struct packed {
        trig_type trig;
        intv_type intv;
    } src_cfg_type;

    localparam src_cfg_type FIXED_CFG = '{trig: TRIG_FALL, intv: INTV_DIV1};

endpackage

// ===== noise_filter.sv
//
// Purpose: sampling noise canceller for one interrupt pin
// Assumes: din already synchronised to mclk
// Notes:   level changes only on a sample tick
//
`timescale 1ns/1ps

module noise_filter
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic sample_tick,
    input  wire logic two_samples,
    input  wire logic din,
    output logic      level
);

    logic samp1_r;
    logic samp2_r;
    logic level_r;
    logic match2_w;
    logic match3_w;
    logic accept_w;
    logic level_nxt;

    // ************************************************************
    // agreement of consecutive samples
    // ************************************************************
    assign match2_w  = (din == samp1_r);
    assign match3_w  = match2_w && (samp1_r == samp2_r);
    assign accept_w  = two_samples ? match2_w : match3_w;
    assign level_nxt = (sample_tick && accept_w) ? din : level_r;
    assign level     = level_r;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            samp1_r <= 1'b0;
            samp2_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            if (sample_tick)
            begin
                samp1_r <= din;
                samp2_r <= samp1_r;
            end
            level_r <= level_nxt;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    only_on_tick_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        $changed(level_r) |-> $past(sample_tick))
        else $error("filter level moved without a sample tick");

    three_agree_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        $changed(level_r) && !$past(two_samples)
            |-> $past(samp1_r) == level_r && $past(samp2_r) == level_r)
        else $error("level accepted without three equal samples");

endmodule

// ===== ext_irq_front.sv
//
// Purpose: six-pin external interrupt front end with noise cancellers
// Assumes: mclk is the gear clock; lf_clk is the low-frequency clock pin
// Notes:   request latch of the processor sits outside; enable and master-flag gating is done here
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

module ext_irq_front
    import ext_irq_pkg::*;
(
    input  wire logic                                mclk,
    input  wire logic                                nrst,
    input  wire logic [ext_irq_pkg::NUM_SRC-1:0]     ext_pin,
    input  wire logic                                lf_clk,
    input  wire ext_irq_pkg::power_mode_type         op_mode,
    input  wire ext_irq_pkg::src_cfg_type            cfg_src1,
    input  wire ext_irq_pkg::src_cfg_type            cfg_src2,
    input  wire ext_irq_pkg::src_cfg_type            cfg_src3,
    input  wire logic                                global_irq_master_flag,
    input  wire logic [ext_irq_pkg::NUM_SRC-1:0]     src_irq_enable,
    input  wire logic [ext_irq_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [ext_irq_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [ext_irq_pkg::DATA_W-1:0]      reg_rdata,
    output logic      [ext_irq_pkg::NUM_SRC-1:0]     irq_detect,
    output logic      [ext_irq_pkg::NUM_SRC-1:0]     irq_to_cpu,
    output logic      [ext_irq_pkg::NUM_SRC-1:0]     filtered_level
);

    import ext_irq_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic        [NUM_SRC-1:0] pin_s1_r;
    logic        [NUM_SRC-1:0] pin_s2_r;
    logic                      lf_s1_r;
    logic                      lf_s2_r;
    logic                      lf_s3_r;
    logic        [1:0]         lf_cnt_r;
    logic        [PRESC_W-1:0] presc_r;
    trig_type                  trig_r;
    intv_type                  intv_r;
    logic                      lvl_r;
    logic        [NUM_SRC-1:0] prev_r;
    logic        [NUM_SRC-1:0] req_r;
    logic        [NUM_SRC-1:0] cpu_r;
    logic        [DATA_W-1:0]  rdata_r;

    logic                      fast_w;
    logic                      slow_w;
    logic                      halt_w;
    logic                      lf_rise_w;
    logic                      slow_tick_w;
    logic                      ctl_hit_w;
    logic                      ctl_wr_w;
    logic                      ctl_rd_w;
    logic        [DATA_W-1:0]  ctl_value_w;
    src_cfg_type [NUM_SRC-1:0] cfg_w;
    logic        [NUM_SRC-1:0] fast_tick_w;
    logic        [NUM_SRC-1:0] tick_w;
    logic        [NUM_SRC-1:0] lvl_w;
    logic        [NUM_SRC-1:0] rise_w;
    logic        [NUM_SRC-1:0] fall_w;
    logic        [NUM_SRC-1:0] req_nxt;
    logic        [NUM_SRC-1:0] cpu_nxt;
    logic        [DATA_W-1:0]  rdata_nxt;

    // ************************************************************
    // helpers
    // ************************************************************
    // fast-mode sample strobe from the free-running prescaler
    function automatic logic interval_tick(intv_type intv, logic [PRESC_W-1:0] cnt);
        logic hit;
        hit = 1'b0;
        unique case (intv)
            INTV_DIV1  : hit = 1'b1;
            INTV_DIV4  : hit = (cnt[1:0] == PRESC_ZERO[1:0]);
            INTV_DIV8  : hit = (cnt[2:0] == PRESC_ZERO[2:0]);
            INTV_DIV16 : hit = (cnt == PRESC_ZERO);
        endcase
        return hit;
    endfunction

    // request condition from the filtered level
    function automatic logic req_of(trig_type t, logic r, logic f, logic lvl, logic lvl_ok);
        logic hit;
        hit = 1'b0;
        unique case (t)
            TRIG_RISE : hit = r;
            TRIG_FALL : hit = f;
            TRIG_BOTH : hit = r | f;
            TRIG_HIGH : hit = lvl & lvl_ok;
        endcase
        return hit;
    endfunction

    // ************************************************************
    // operating mode decode
    // ************************************************************
    assign fast_w = (op_mode == MODE_FAST);
    assign slow_w = (op_mode == MODE_SLOW);
    assign halt_w = !fast_w && !slow_w;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end
        else
        begin
            pin_s1_r <= ext_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ************************************************************
    // low-frequency clock divided by four
    // ************************************************************
    assign lf_rise_w   = lf_s2_r && !lf_s3_r;
    assign slow_tick_w = lf_rise_w && (lf_cnt_r == LF_DIV_LAST);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lf_s1_r  <= 1'b0;
            lf_s2_r  <= 1'b0;
            lf_s3_r  <= 1'b0;
            lf_cnt_r <= '0;
        end
        else
        begin
            lf_s1_r  <= lf_clk;
            lf_s2_r  <= lf_s1_r;
            lf_s3_r  <= lf_s2_r;
            lf_cnt_r <= lf_rise_w ? lf_cnt_r + LF_STEP : lf_cnt_r;
        end
    end

    // ************************************************************
    // gear clock prescaler
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            presc_r <= PRESC_ZERO;
        else
            presc_r <= presc_r + PRESC_STEP;
    end

    // ************************************************************
    // source configuration
    // ************************************************************
    // sources 0 and 5 ignore any setting
    assign cfg_w[0] = FIXED_CFG;
    assign cfg_w[1] = cfg_src1;
    assign cfg_w[2] = cfg_src2;
    assign cfg_w[3] = cfg_src3;
    assign cfg_w[4] = '{trig: trig_r, intv: intv_r};
    assign cfg_w[5] = FIXED_CFG;

    // ************************************************************
    // per-source filter and edge detection
    // ************************************************************
    for (genvar gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
        localparam logic FIXED = FIXED_MASK[gi];

        // fixed sources sample every gear clock in fast mode, two agreeing samples
        assign fast_tick_w[gi] = FIXED ? 1'b1 : interval_tick(cfg_w[gi].intv, presc_r);
        assign tick_w[gi]      = (fast_w && fast_tick_w[gi]) || (slow_w && slow_tick_w);

        noise_filter u_filter
        (
            .mclk        (mclk),
            .nrst        (nrst),
            .sample_tick (tick_w[gi]),
            .two_samples (FIXED || slow_w),
            .din         (pin_s2_r[gi]),
            .level       (lvl_w[gi])
        );

        assign rise_w[gi]  = lvl_w[gi] && !prev_r[gi];
        assign fall_w[gi]  = !lvl_w[gi] && prev_r[gi];
        assign req_nxt[gi] = !halt_w && req_of(cfg_w[gi].trig, rise_w[gi], fall_w[gi],
                                               lvl_w[gi], (gi == LVL_SRC));
    end

    // ************************************************************
    // request and processor gating
    // ************************************************************
    assign cpu_nxt = req_nxt & src_irq_enable & {NUM_SRC{global_irq_master_flag}};

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_r <= '0;
            req_r  <= '0;
            cpu_r  <= '0;
        end
        else
        begin
            prev_r <= lvl_w;
            req_r  <= req_nxt;
            cpu_r  <= cpu_nxt;
        end
    end

    assign irq_detect     = req_r;
    assign irq_to_cpu     = cpu_r;
    assign filtered_level = prev_r;

    // ************************************************************
    // control register of the fourth source
    // ************************************************************
    assign ctl_hit_w   = (reg_addr == CTL4_ADDR);
    assign ctl_wr_w    = reg_wr && ctl_hit_w;
    assign ctl_rd_w    = reg_rd && ctl_hit_w;
    assign ctl_value_w = {RSVD_VALUE, lvl_r, trig_r, intv_r};
    assign rdata_nxt   = ctl_rd_w ? ctl_value_w : RDATA_IDLE;

    // new settings act at once; a change may itself look like an edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            trig_r <= trig_type'(CTL4_RESET[TRIG_LSB +: 2]);
            intv_r <= intv_type'(CTL4_RESET[INTV_LSB +: 2]);
        end
        else if (ctl_wr_w)
        begin
            trig_r <= trig_type'(reg_wdata[TRIG_LSB +: 2]);
            intv_r <= intv_type'(reg_wdata[INTV_LSB +: 2]);
        end
    end

    // captured level follows the filter at each source-4 request
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            lvl_r <= CTL4_RESET[LVL_BIT];
        else if (req_nxt[LVL_SRC])
            lvl_r <= lvl_w[LVL_SRC];
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rdata_r <= RDATA_IDLE;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // ************************************************************
    // checks
    // ************************************************************
    rsvd_read_zero_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd && reg_addr == CTL4_ADDR |=> reg_rdata[RSVD_MSB:RSVD_LSB] == RSVD_VALUE)
        else $error("reserved control bits read nonzero");

    level_capture_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        req_nxt[LVL_SRC] |=> lvl_r == $past(lvl_w[LVL_SRC]))
        else $error("captured level not taken at request");

    level_hold_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        !req_nxt[LVL_SRC] |=> $stable(lvl_r))
        else $error("captured level moved without request");

    rise_request_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        trig_r == TRIG_RISE && !halt_w && $rose(lvl_w[LVL_SRC]) |=> req_r[LVL_SRC])
        else $error("rising edge request missed");

    high_level_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        trig_r == TRIG_HIGH && !halt_w && lvl_w[LVL_SRC] |=> req_r[LVL_SRC])
        else $error("high level request missed");

    fixed_fall_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        req_r[0] == $past(fall_w[0] && !halt_w))
        else $error("source 0 request not on falling edge");

    cpu_gate_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        |irq_to_cpu |-> $past(global_irq_master_flag))
        else $error("request passed with master flag clear");

    halt_quiet_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        $past(halt_w) |-> $stable(lvl_w) && req_r == '0)
        else $error("detection active in halted mode");

    div16_spacing_a : assert property (
        @(posedge mclk) disable iff (!nrst)
        intv_r == INTV_DIV16 && fast_tick_w[LVL_SRC]
            |-> presc_r == PRESC_ZERO ##16 (fast_tick_w[LVL_SRC] || intv_r != INTV_DIV16))
        else $error("sixteen-cycle sampling interval broken");

    rise_seen_c : cover property (
        @(posedge mclk) disable iff (!nrst)
        trig_r == TRIG_RISE && req_r[LVL_SRC]);

    both_edges_c : cover property (
        @(posedge mclk) disable iff (!nrst)
        trig_r == TRIG_BOTH && req_r[LVL_SRC] && !lvl_r);

    slow_accept_c : cover property (
        @(posedge mclk) disable iff (!nrst)
        slow_w && $changed(lvl_w[5]));

    cpu_request_c : cover property (
        @(posedge mclk) disable iff (!nrst)
        irq_to_cpu[5]);

endmodule

// ===== pin_source.sv
//
// Purpose: board-side model of the six interrupt pins and the low-frequency clock
// Assumes: pins idle low after power-up; low-frequency clock runs free
// Notes:   width 0 on pulse gives a sub-cycle glitch between two mclk edges
//
`timescale 1ns/1ps

module pin_source
(
    input  wire logic       mclk,
    output logic      [5:0] ext_pin,
    output logic            lf_clk
);
    // lf period of 8 mclk cycles, phase unrelated to mclk
    localparam int LF_HALF_NS = 200;

    initial
    begin
        ext_pin = 6'h00;
        lf_clk  = 1'b0;
        #37;
        forever #LF_HALF_NS lf_clk = ~lf_clk;
    end

    task automatic set_pin(input int src, input logic lvl);
        @(posedge mclk);
        ext_pin[src] <= lvl;
    endtask

    task automatic pulse(input int src, input logic lvl, input int width);
        @(posedge mclk);
        if (width == 0)
        begin
            #15 ext_pin[src] = lvl;
            #20 ext_pin[src] = ~lvl;
        end
        else
        begin
            ext_pin[src] <= lvl;
            repeat (width) @(posedge mclk);
            ext_pin[src] <= ~lvl;
        end
    endtask
endmodule

// ===== tb_top.sv
//
// Purpose: self-checking bench for the external interrupt front end
// Assumes: lf clock period is 8 mclk cycles
// Notes:   pulse widths and windows are in mclk cycles
//
`timescale 1ns/1ps

module tb_top;
    import ext_irq_pkg::*;

    logic                mclk;
    logic                nrst;
    logic                lf_clk;
    logic [NUM_SRC-1:0]  ext_pin;
    power_mode_type      op_mode;
    src_cfg_type         cfg_src1;
    src_cfg_type         cfg_src2;
    src_cfg_type         cfg_src3;
    logic                global_irq_master_flag;
    logic [NUM_SRC-1:0]  src_irq_enable;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [DATA_W-1:0]   reg_rdata;
    logic [NUM_SRC-1:0]  irq_detect;
    logic [NUM_SRC-1:0]  irq_to_cpu;
    logic [NUM_SRC-1:0]  filtered_level;
    logic [7:0]          rdv;
    int                  bad_count;
    int                  num_checks;
    int                  f;
    int                  cnt3 [3] = '{1, 0, 2};
    int                  tcnt [4] = '{1, 1, 2, 20};
    logic                tlvl [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    initial mclk = 1'b0;
    always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

    ext_irq_front u_dut
    (
        .mclk, .nrst, .ext_pin, .lf_clk, .op_mode, .cfg_src1, .cfg_src2, .cfg_src3,
        .global_irq_master_flag, .src_irq_enable, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq_detect, .irq_to_cpu, .filtered_level
    );

    pin_source u_pins
    (
        .mclk    (mclk),
        .ext_pin (ext_pin),
        .lf_clk  (lf_clk)
    );

    // ************************************************************
    // bus, compare and stimulus tasks
    // ************************************************************
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t reg got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            bad_count++;
            $display("ERROR t=%0t count got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_lvl(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t level got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // pulse one pin, count requests and gated requests over the window
    task automatic stim(input int src, input logic lvl, input int width,
                        input int window, input int exp);
        int nd;
        int nc;
        int ne;
        nd = 0;
        nc = 0;
        fork
            u_pins.pulse(src, lvl, width);
            repeat (window)
            begin
                @(posedge mclk);
                #1;
                // an unknown counts as a request so that it cannot pass
                if (irq_detect[src] !== 1'b0)
                    nd++;
                if (irq_to_cpu[src] !== 1'b0)
                    nc++;
            end
        join
        ne = (global_irq_master_flag === 1'b1 && src_irq_enable[src] === 1'b1) ? exp : 0;
        chk_cnt(nd, exp);
        chk_cnt(nc, ne);
        chk_lvl(filtered_level[src], ~lvl);
        // hand back on a rising edge so callers drive there
        @(posedge mclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        $display("ERROR t=%0t watchdog got=%0h exp=%0h", $time, 0, 1);
        end_sim;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        nrst = 1'b0;
        op_mode = MODE_FAST;
        cfg_src1 = src_cfg_type'(4'h0);
        cfg_src2 = src_cfg_type'(4'hc);
        cfg_src3 = src_cfg_type'(4'h8);
        global_irq_master_flag = 1'b1;
        src_irq_enable = 6'h21;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        rd(CTL4_ADDR, rdv);
        chk_reg(rdv, CTL4_RESET);
        wr(CTL4_ADDR, 8'hff);
        rd(CTL4_ADDR, rdv);
        chk_reg(rdv, 8'h0f);
        wr(12'hfdc, 8'h03);
        rd(CTL4_ADDR, rdv);
        chk_reg(rdv, 8'h0f);
        rd(12'hfdc, rdv);
        chk_reg(rdv, RDATA_IDLE);
        u_pins.set_pin(0, 1'b1);
        u_pins.set_pin(5, 1'b1);
        repeat (12) @(posedge mclk);
        for (int s = 0; s < NUM_SRC; s += 5)
        begin
            stim(s, 1'b0, 0, 12, 0);
            stim(s, 1'b0, 2, 14, 1);
        end
        global_irq_master_flag <= 1'b0;
        stim(0, 1'b0, 4, 14, 1);
        global_irq_master_flag <= 1'b1;
        // sources masked in the same cycle as the change to halted mode
        src_irq_enable <= 6'h00;
        op_mode <= MODE_HALT;
        stim(0, 1'b0, 20, 30, 0);
        op_mode <= MODE_FAST;
        repeat (10) @(posedge mclk);
        src_irq_enable <= 6'h08;
        for (int s = 1; s < 4; s++)
            stim(s, 1'b1, 6, 20, cnt3[s-1]);
        src_irq_enable <= 6'h00;
        for (int t = 0; t < 4; t++)
        begin
            wr(CTL4_ADDR, {4'h0, t[1:0], 2'h0});
            repeat (4) @(posedge mclk);
            stim(4, 1'b1, 20, 34, tcnt[t]);
            rd(CTL4_ADDR, rdv);
            chk_reg(rdv, {3'h0, tlvl[t], t[1:0], 2'h0});
        end
        for (int v = 0; v < 4; v++)
        begin
            f = (v == 0) ? 1 : (1 << (v + 1));
            wr(CTL4_ADDR, {6'h0, v[1:0]});
            repeat (40) @(posedge mclk);
            stim(4, 1'b1, 2 * f - 1, 2 * f + 40, 0);
            stim(4, 1'b1, 3 * f + 1, 7 * f + 10, 1);
        end
        op_mode <= MODE_SLOW;
        repeat (96) @(posedge mclk);
        stim(5, 1'b0, 24, 60, 0);
        stim(5, 1'b0, 72, 150, 1);
        wr(CTL4_ADDR, 8'h03);
        stim(4, 1'b1, 24, 60, 0);
        stim(4, 1'b1, 72, 150, 1);
        op_mode <= MODE_FAST;
        repeat (20) @(posedge mclk);
        end_sim;
    end
endmodule
